// *** wcm_top.sv ***
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module wcm_top (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        hosc_clk_i,
  input  wire logic        losc_clk_i,
  input  wire logic        wake_i,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             hosc_en_o,
  output logic             losc_en_o,
  output logic             hs_tap_run_o,
  output logic             cpu_run_o,
  output logic             periph_run_o,
  output logic [1:0]       sysclk_src_o,
  output logic [2:0]       sysclk_div_o
);

  logic [7:0]      mode_r, wdog_r, ocfg_r, waddr_r, wdata_r;
  logic            wstrb0_r;
  logic            awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0]      bresp_r, rresp_r;
  logic [7:0]      rdata_r;
  wcm_pkg::wcm_pm_t st_r, st_nxt;
  logic            fw_r, fw_nxt, eff_low_r;
  logic [1:0]      fw_cnt_r;
  logic            hosc_en_r, losc_en_r, tap_r, cpu_r, periph_r;
  logic [1:0]      src_r;
  logic [2:0]      div_r;
  logic            hi_rise, lo_rise, wake_rise;

  wcm_osc_if hi_if ();
  wcm_osc_if lo_if ();

  // Oscillators are sampled as pins: fine while they run below 12.5 MHz, as each level must hold for two samples
  wcm_sync u_hsync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .pin_i   (hosc_clk_i),
    .level_o (),
    .rise_o  (hi_rise)
  );
  wcm_sync u_lsync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .pin_i   (losc_clk_i),
    .level_o (),
    .rise_o  (lo_rise)
  );
  wcm_sync u_wsync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .pin_i   (wake_i),
    .level_o (),
    .rise_o  (wake_rise)
  );

  wcm_stab u_hstab (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .osc     (hi_if.cnt)
  );
  wcm_stab u_lstab (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .osc     (lo_if.cnt)
  );

  // Field decode
  wire [2:0] div_fld = mode_r[wcm_pkg::MODE_DIV_LSB +: 3];
  wire       hlsel   = mode_r[wcm_pkg::MODE_HLSEL];
  wire       fwe     = mode_r[wcm_pkg::MODE_FWE];
  wire       idle_en = mode_r[wcm_pkg::MODE_IDLE];
  wire       sys_idl = wdog_r[wcm_pkg::WDOG_SYSIDLE];
  wire       wdog_on = wdog_r[wcm_pkg::WDOG_ON];
  wire       hxtal   = (ocfg_r[1:0] == wcm_pkg::HOSC_XTAL);
  wire       lrc     = ocfg_r[wcm_pkg::OCFG_LRC];
  wire       hrdy    = hi_if.ready;
  wire       lrdy    = lo_if.ready;
  wire       req_low = !hlsel && wcm_pkg::is_low_code(div_fld);
  wire       run_pm  = (st_r == wcm_pkg::PM_RUN);
  wire       clk_pm  = run_pm || (st_r == wcm_pkg::PM_IDLE_RUN);
  wire       src_rdy = eff_low_r ? lrdy : hrdy;

  assign hi_if.en    = hosc_en_r;
  assign hi_if.tick  = hi_rise;
  assign hi_if.limit = hxtal ? wcm_pkg::XTAL_STAB_CYC : wcm_pkg::HRC_STAB_CYC;
  assign lo_if.en    = losc_en_r;
  assign lo_if.tick  = lo_rise;
  assign lo_if.limit = lrc ? wcm_pkg::LRC_STAB_CYC : wcm_pkg::XTAL_STAB_CYC;

  // Bus decode
  wire wr_fire  = !awready_r && !wready_r && !bvalid_r;
  wire wr_ok    = wr_fire && wstrb0_r;
  wire wr_mode  = wr_ok && (waddr_r == wcm_pkg::ADDR_MODE);
  wire wr_wdog  = wr_ok && (waddr_r == wcm_pkg::ADDR_WDOG);
  wire wr_ocfg  = wr_ok && (waddr_r == wcm_pkg::ADDR_OCFG);
  wire wr_map   = (waddr_r == wcm_pkg::ADDR_MODE) || (waddr_r == wcm_pkg::ADDR_WDOG)
               || (waddr_r == wcm_pkg::ADDR_OCFG) || (waddr_r == wcm_pkg::ADDR_HALT)
               || (waddr_r == wcm_pkg::ADDR_STAT);
  wire halt_go  = wr_ok && (waddr_r == wcm_pkg::ADDR_HALT)
               && wdata_r[wcm_pkg::HALT_GO] && run_pm;
  wire ar_fire  = s_axi_arvalid && arready_r;
  wire [7:0] mode_rd = {mode_r[7:4], lrdy, hrdy, mode_r[1:0]};
  wire [7:0] stat_rd = {cpu_r, fw_r, eff_low_r, 2'h0, st_r};
  wire       rd_map  = (s_axi_araddr == wcm_pkg::ADDR_MODE)
                    || (s_axi_araddr == wcm_pkg::ADDR_WDOG)
                    || (s_axi_araddr == wcm_pkg::ADDR_OCFG)
                    || (s_axi_araddr == wcm_pkg::ADDR_HALT)
                    || (s_axi_araddr == wcm_pkg::ADDR_STAT);
  wire [7:0] rd_byte =
      (s_axi_araddr == wcm_pkg::ADDR_MODE) ? mode_rd :
      (s_axi_araddr == wcm_pkg::ADDR_WDOG) ? wdog_r  :
      (s_axi_araddr == wcm_pkg::ADDR_OCFG) ? ocfg_r  :
      (s_axi_araddr == wcm_pkg::ADDR_STAT) ? stat_rd : 8'h00;

  // fast wake needs the sub clock alive and the crystal as target
  wire from_sub = (st_r == wcm_pkg::PM_SLEEP_LIGHT) || (st_r == wcm_pkg::PM_IDLE_STOP);
  // enable gates the temporary sub clock
  // RC system oscillators never use it
  wire fast_ok  = fwe && hxtal && !eff_low_r && from_sub && lrdy;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      wcm_pkg::PM_RUN: begin
        if (halt_go) begin
          if (idle_en) st_nxt = sys_idl ? wcm_pkg::PM_IDLE_RUN : wcm_pkg::PM_IDLE_STOP;
          // watchdog off means deep sleep, sub clock stopped
          else st_nxt = wdog_on ? wcm_pkg::PM_SLEEP_LIGHT : wcm_pkg::PM_SLEEP_DEEP;
        end
      end
      wcm_pkg::PM_IDLE_RUN, wcm_pkg::PM_IDLE_STOP,
      wcm_pkg::PM_SLEEP_LIGHT, wcm_pkg::PM_SLEEP_DEEP: begin
        if (wake_rise) st_nxt = wcm_pkg::PM_RUN;
      end
      default: st_nxt = wcm_pkg::PM_RUN;
    endcase
  end

  // deep sleep is not in from_sub, so the enable is ignored there
  // sub clock carries the system until the crystal flag rises
  assign fw_nxt = (wake_rise && !run_pm) ? fast_ok : (fw_r && !hrdy && run_pm);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r      <= wcm_pkg::PM_RUN;
      fw_r      <= 1'b0;
      fw_cnt_r  <= 2'h0;
      eff_low_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      fw_r <= fw_nxt;
      if (!fw_r) fw_cnt_r <= 2'h0;
      else if (lo_rise && fw_cnt_r != wcm_pkg::SUB_WAKE_CYC) fw_cnt_r <= fw_cnt_r + 2'h1;
      // the selected source takes over only once it is stable
      if (clk_pm && req_low && lrdy) eff_low_r <= 1'b1;
      else if (clk_pm && !req_low && hrdy) eff_low_r <= 1'b0;
    end
  end

  // Clock outputs, one cycle behind the state they follow
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      hosc_en_r <= 1'b1;
      losc_en_r <= 1'b0;
      tap_r     <= 1'b0;
      cpu_r     <= 1'b0;
      periph_r  <= 1'b0;
      src_r     <= wcm_pkg::SRC_HIGH;
      div_r     <= 3'h0;
    end else begin
      // low clock in use stops the high oscillator and its taps
      // high oscillator off in sleep and clock-stopped idle
      hosc_en_r <= clk_pm && !(req_low && eff_low_r);
      tap_r     <= hosc_en_r && hrdy;
      // low oscillator off in deep sleep
      losc_en_r <= (st_r != wcm_pkg::PM_SLEEP_DEEP)
                && (wdog_on || req_low || eff_low_r || fw_r || !run_pm);
      // sub clock wake takes two of its cycles
      cpu_r     <= run_pm && (fw_r ? (fw_cnt_r == wcm_pkg::SUB_WAKE_CYC) : src_rdy);
      periph_r  <= clk_pm && (fw_r || src_rdy);
      if (!clk_pm) src_r <= wcm_pkg::SRC_OFF;
      else if (fw_r) src_r <= wcm_pkg::SRC_SUB;
      else if (eff_low_r) src_r <= wcm_pkg::SRC_LOW;
      else src_r <= wcm_pkg::SRC_HIGH;
      if (fw_r || eff_low_r || hlsel || req_low) div_r <= 3'h0;
      else div_r <= wcm_pkg::div_shift(div_fld);
    end
  end

  // Registers and AXI4-Lite slave
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_r    <= wcm_pkg::MODE_RST;
      wdog_r    <= wcm_pkg::WDOG_RST;
      ocfg_r    <= wcm_pkg::OCFG_RST;
      waddr_r   <= 8'h00;
      wdata_r   <= 8'h00;
      wstrb0_r  <= 1'b0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= wcm_pkg::AXI_OKAY;
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= wcm_pkg::AXI_OKAY;
      rdata_r   <= 8'h00;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        waddr_r   <= s_axi_awaddr;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid && wready_r) begin
        wdata_r  <= s_axi_wdata[7:0];
        wstrb0_r <= s_axi_wstrb[0];
        wready_r <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_map ? wcm_pkg::AXI_OKAY : wcm_pkg::AXI_SLVERR;
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
      if (wr_mode) mode_r <= (mode_r & ~wcm_pkg::MODE_WMSK) | (wdata_r & wcm_pkg::MODE_WMSK);
      if (wr_wdog) wdog_r <= wdata_r & wcm_pkg::WDOG_WMSK;
      if (wr_ocfg) ocfg_r <= wdata_r & wcm_pkg::OCFG_WMSK;
      if (ar_fire) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rdata_r   <= rd_byte;
        rresp_r   <= rd_map ? wcm_pkg::AXI_OKAY : wcm_pkg::AXI_SLVERR;
      end
      if (rvalid_r && s_axi_rready) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = {24'h000000, rdata_r};
  assign hosc_en_o     = hosc_en_r;
  assign losc_en_o     = losc_en_r;
  assign hs_tap_run_o  = tap_r;
  assign cpu_run_o     = cpu_r;
  assign periph_run_o  = periph_r;
  assign sysclk_src_o  = src_r;
  assign sysclk_div_o  = div_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  chk_fast_from_sub: assert property (
    $rose(fw_r) |-> ($past(st_r) == wcm_pkg::PM_SLEEP_LIGHT
                  || $past(st_r) == wcm_pkg::PM_IDLE_STOP))
    else $error("fast wake from wrong mode");
  chk_deep_no_fast: assert property (
    (st_r == wcm_pkg::PM_SLEEP_DEEP && wake_rise) |=> !fw_r)
    else $error("fast wake after deep sleep");
  chk_fast_enable: assert property (
    $rose(fw_r) |-> $past(fwe))
    else $error("fast wake while disabled");
  chk_fast_handover: assert property (
    (fw_r && hrdy) |=> !fw_r ##1 (src_r == wcm_pkg::SRC_HIGH))
    else $error("no hand over to crystal");
  chk_rc_no_fast: assert property (
    fw_r |-> hxtal)
    else $error("fast wake with RC oscillator");
  chk_halt_idle: assert property (
    (halt_go && idle_en && sys_idl) |=> (st_r == wcm_pkg::PM_IDLE_RUN) ##1 periph_run_o == $past(src_rdy))
    else $error("halt idle decode wrong");
  chk_halt_sleep: assert property (
    (halt_go && !idle_en) |=> (st_r == (wdog_on ? wcm_pkg::PM_SLEEP_LIGHT
                                               : wcm_pkg::PM_SLEEP_DEEP)))
    else $error("halt sleep decode wrong");
  chk_high_stop: assert property (
    (clk_pm && eff_low_r && req_low) |=> !hosc_en_o ##1 !hs_tap_run_o)
    else $error("high oscillator not stopped");
  chk_low_switch: assert property (
    $rose(eff_low_r) |-> $past(lrdy))
    else $error("slow switch before low ready");
  chk_flags_deep: assert property (
    (st_r == wcm_pkg::PM_SLEEP_DEEP) [*3] |-> !hrdy && !lrdy)
    else $error("ready flag high in deep sleep");
  chk_div_field: assert property (
    (clk_pm && !fw_r && !eff_low_r && !req_low && !hlsel)
      |=> sysclk_div_o == wcm_pkg::div_shift($past(div_fld)))
    else $error("divider code wrong");
  chk_div_full: assert property (
    (clk_pm && hlsel) |=> sysclk_div_o == 3'h0)
    else $error("select high not undivided");

  cov_fast_wake: cover property ($rose(fw_r) ##[1:1000] !fw_r);
  cov_deep_wake: cover property (st_r == wcm_pkg::PM_SLEEP_DEEP ##1 st_r == wcm_pkg::PM_RUN);
  cov_slow_mode: cover property ($rose(eff_low_r));
  cov_idle_run:  cover property (st_r == wcm_pkg::PM_IDLE_RUN);

endmodule
`default_nettype wire

// *** wcm_pkg.sv ***
`default_nettype none
package wcm_pkg;

  // Register byte addresses on the AXI4-Lite slave
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_WDOG = 8'h04;
  localparam logic [7:0] ADDR_OCFG = 8'h08;
  localparam logic [7:0] ADDR_HALT = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;

  // mode_control_register fields
  localparam int MODE_DIV_LSB = 5;
  localparam int MODE_FWE     = 4;
  localparam int MODE_LRDY    = 3;
  localparam int MODE_HRDY    = 2;
  localparam int MODE_IDLE    = 1;
  localparam int MODE_HLSEL   = 0;
  localparam logic [7:0] MODE_RST  = 8'h03;
  localparam logic [7:0] MODE_WMSK = 8'hf3;

  // watchdog_control_register fields
  localparam int WDOG_SYSIDLE = 0;
  localparam int WDOG_ON      = 1;
  localparam logic [7:0] WDOG_RST  = 8'h02;
  localparam logic [7:0] WDOG_WMSK = 8'h03;

  // Oscillator fit-out: [1:0] high type, [2] low type (1 = internal RC)
  localparam int OCFG_LRC = 2;
  localparam logic [7:0] OCFG_RST  = 8'h00;
  localparam logic [7:0] OCFG_WMSK = 8'h07;
  localparam int HALT_GO = 0;

  // Stabilisation counts, in cycles of the oscillator concerned
  localparam logic [10:0] XTAL_STAB_CYC = 11'h400;
  localparam logic [10:0] HRC_STAB_CYC  = 11'h010;
  localparam logic [10:0] LRC_STAB_CYC  = 11'h002;
  localparam logic [1:0]  SUB_WAKE_CYC  = 2'h2;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    HOSC_XTAL = 2'b00,
    HOSC_EXTRC = 2'b01,
    HOSC_IRC  = 2'b10
  } wcm_hosc_t;

  typedef enum logic [2:0] {
    PM_RUN         = 3'b000,
    PM_IDLE_RUN    = 3'b001,
    PM_IDLE_STOP   = 3'b010,
    PM_SLEEP_LIGHT = 3'b011,
    PM_SLEEP_DEEP  = 3'b100
  } wcm_pm_t;

  typedef enum logic [1:0] {
    SRC_HIGH = 2'b00,
    SRC_LOW  = 2'b01,
    SRC_SUB  = 2'b10,
    SRC_OFF  = 2'b11
  } wcm_src_t;

  // Divider codes 000 and 001 pick the low-speed clock
  function automatic logic is_low_code(input logic [2:0] f);
    return f <= 3'h1;
  endfunction

  // Log2 of the high-speed divisor: 010 -> /64 ... 111 -> /2
  function automatic logic [2:0] div_shift(input logic [2:0] f);
    logic [3:0] t;
    t = 4'h8 - {1'b0, f};
    return t[2:0];
  endfunction

endpackage
`default_nettype wire

// *** wcm_osc_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface wcm_osc_if;
  logic        en;
  logic        tick;
  logic [10:0] limit;
  logic        ready;
  modport ctl (output en, tick, limit, input ready);
  modport cnt (input en, tick, limit, output ready);
endinterface
`default_nettype wire

// *** wcm_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module wcm_sync (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o
);
  logic s1_r, s2_r, s3_r, level_r, rise_r;
  wire  agree = (s2_r == s3_r);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
      rise_r  <= 1'b0;
    end else begin
      s1_r    <= pin_i;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      rise_r  <= agree && s3_r && !level_r;
      if (agree) level_r <= s3_r;
    end
  end

  assign level_o = level_r;
  assign rise_o  = rise_r;
endmodule
`default_nettype wire

// *** wcm_stab.sv ***
`timescale 1ns/10ps
`default_nettype none
module wcm_stab (
  input wire logic clk_i,
  input wire logic reset_i,
  wcm_osc_if.cnt   osc
);
  logic [10:0] cnt_r;
  logic        rdy_r;

  // Disabling the oscillator drops the flag and restarts the count
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_r <= 11'h000;
      rdy_r <= 1'b0;
    end else if (!osc.en) begin
      cnt_r <= 11'h000;
      rdy_r <= 1'b0;
    end else if (osc.tick && !rdy_r) begin
      cnt_r <= cnt_r + 11'h001;
      if (cnt_r == osc.limit - 11'h001) rdy_r <= 1'b1;
    end
  end

  assign osc.ready = rdy_r;
endmodule
`default_nettype wire

// *** wcm_top_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module wcm_top_tb;
  logic        clk_i;
  logic        reset_i;
  logic        hosc_clk_i;
  logic        losc_clk_i;
  logic        wake_i;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        hosc_en_o;
  logic        losc_en_o;
  logic        hs_tap_run_o;
  logic        cpu_run_o;
  logic        periph_run_o;
  logic [1:0]  sysclk_src_o;
  logic [2:0]  sysclk_div_o;
  logic [3:0]  hcnt;
  logic [3:0]  lcnt;
  int          failures;
  int          checks;

  wcm_top u_dut (.clk_i, .reset_i, .hosc_clk_i, .losc_clk_i, .wake_i,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .hosc_en_o, .losc_en_o, .hs_tap_run_o,
    .cpu_run_o, .periph_run_o, .sysclk_src_o, .sysclk_div_o);

  always #10 clk_i = ~clk_i;

  // High oscillator about 8.3 MHz, low one 2.5 MHz: both well under the sync limit
  always @(posedge clk_i) begin
    hcnt <= (hcnt == 4'h2) ? 4'h0 : hcnt + 4'h1;
    lcnt <= (lcnt == 4'h9) ? 4'h0 : lcnt + 4'h1;
    if (hcnt == 4'h2) hosc_clk_i <= ~hosc_clk_i;
    if (lcnt == 4'h9) losc_clk_i <= ~losc_clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // No local limit: only the bench watchdog ends a hung handshake
    do begin
      @(posedge clk_i);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er, "write response");
    // Let the ready lines return before a next request starts
    @(posedge clk_i);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk(s_axi_rresp, er, "read response");
    @(posedge clk_i);
  endtask

  task automatic wait_hrdy();
    int i;
    logic [31:0] d;
    i = 0;
    do begin
      axi_read(wcm_pkg::ADDR_MODE, d, wcm_pkg::AXI_OKAY);
      i++;
    end while (d[wcm_pkg::MODE_HRDY] !== 1'b1 && i < 3000);
    chk(d[wcm_pkg::MODE_HRDY], 1'b1, "high ready");
  endtask

  task automatic wait_src(input logic [1:0] s, input int lim);
    int i;
    i = 0;
    while (sysclk_src_o !== s && i < lim) begin
      @(posedge clk_i);
      i++;
    end
  endtask

  task automatic t_regs();
    logic [31:0] d;
    axi_read(wcm_pkg::ADDR_MODE, d, wcm_pkg::AXI_OKAY);
    chk(d, 32'h00000003, "mode reset");
    axi_read(wcm_pkg::ADDR_WDOG, d, wcm_pkg::AXI_OKAY);
    chk(d, 32'h00000002, "watchdog reset");
    axi_read(8'h14, d, wcm_pkg::AXI_SLVERR);
    chk(d, 32'h00000000, "unmapped read");
    axi_write(8'h18, 8'h55, wcm_pkg::AXI_SLVERR);
    axi_write(wcm_pkg::ADDR_OCFG, 8'hfc, wcm_pkg::AXI_OKAY);
    axi_read(wcm_pkg::ADDR_OCFG, d, wcm_pkg::AXI_OKAY);
    chk(d, 32'h00000004, "osc config mask");
    wait_hrdy();
    repeat (4) @(posedge clk_i);
    chk(cpu_run_o, 1'b1, "cpu running");
    chk(sysclk_src_o, wcm_pkg::SRC_HIGH, "start on high");
    $display("test regs done");
  endtask

  task automatic t_slow();
    logic [31:0] d;
    int e;
    // Select low, divider 001
    axi_write(wcm_pkg::ADDR_MODE, 8'h20, wcm_pkg::AXI_OKAY);
    wait_src(wcm_pkg::SRC_LOW, 500);
    chk(sysclk_src_o, wcm_pkg::SRC_LOW, "slow on 001");
    repeat (4) @(posedge clk_i);
    chk(hosc_en_o, 1'b0, "high osc stopped");
    chk(hs_tap_run_o, 1'b0, "taps stopped");
    chk(sysclk_div_o, 3'h0, "no divide on low");
    axi_read(wcm_pkg::ADDR_MODE, d, wcm_pkg::AXI_OKAY);
    chk(d[wcm_pkg::MODE_LRDY], 1'b1, "low ready");
    axi_write(wcm_pkg::ADDR_MODE, 8'h00, wcm_pkg::AXI_OKAY);
    repeat (4) @(posedge clk_i);
    chk(sysclk_src_o, wcm_pkg::SRC_LOW, "slow on 000");
    for (int c = 2; c < 8; c++) begin
      axi_write(wcm_pkg::ADDR_MODE, {c[2:0], 5'h00}, wcm_pkg::AXI_OKAY);
      wait_hrdy();
      wait_src(wcm_pkg::SRC_HIGH, 50);
      repeat (2) @(posedge clk_i);
      e = 8 - c;
      chk(sysclk_src_o, wcm_pkg::SRC_HIGH, "divided high");
      chk(sysclk_div_o, e[2:0], "divider code");
      chk(hs_tap_run_o, 1'b1, "taps running");
    end
    axi_write(wcm_pkg::ADDR_MODE, 8'h41, wcm_pkg::AXI_OKAY);
    repeat (4) @(posedge clk_i);
    chk(sysclk_div_o, 3'h0, "select overrides divider");
    chk(sysclk_src_o, wcm_pkg::SRC_HIGH, "select high");
    $display("test slow switch done");
  endtask

  task automatic wake_case(input logic [7:0] wd, input logic [7:0] mv, input logic [2:0] pm,
                           input logic exp_sub, input logic exp_quick);
    logic [31:0] d;
    logic        sub;
    logic [1:0]  es;
    int          n;
    axi_write(wcm_pkg::ADDR_WDOG, wd, wcm_pkg::AXI_OKAY);
    // Low oscillator may just have been switched on: let its ready flag settle first
    repeat (60) @(posedge clk_i);
    axi_write(wcm_pkg::ADDR_MODE, mv, wcm_pkg::AXI_OKAY);
    axi_write(wcm_pkg::ADDR_HALT, 8'h01, wcm_pkg::AXI_OKAY);
    repeat (4) @(posedge clk_i);
    axi_read(wcm_pkg::ADDR_STAT, d, wcm_pkg::AXI_OKAY);
    chk(d[2:0], pm, "halt mode");
    chk(cpu_run_o, 1'b0, "cpu halted");
    chk(periph_run_o, pm == wcm_pkg::PM_IDLE_RUN, "peripheral clock");
    chk(hosc_en_o, pm == wcm_pkg::PM_IDLE_RUN, "high osc in halt");
    es = (pm == wcm_pkg::PM_IDLE_RUN) ? wcm_pkg::SRC_HIGH : wcm_pkg::SRC_OFF;
    chk(sysclk_src_o, es, "source in halt");
    chk(losc_en_o, pm != wcm_pkg::PM_SLEEP_DEEP, "low osc in halt");
    axi_read(wcm_pkg::ADDR_MODE, d, wcm_pkg::AXI_OKAY);
    chk(d[wcm_pkg::MODE_HRDY], pm == wcm_pkg::PM_IDLE_RUN, "high ready in halt");
    wake_i <= 1'b1;
    n = 0;
    sub = 1'b0;
    // Wake held for 8 cycles so the synchroniser surely sees it
    while ((cpu_run_o !== 1'b1 || n < 8) && n < 12000) begin
      @(posedge clk_i);
      n++;
      if (sysclk_src_o === wcm_pkg::SRC_SUB) sub = 1'b1;
      if (n == 8) wake_i <= 1'b0;
    end
    chk(cpu_run_o, 1'b1, "woken");
    chk(sub, exp_sub, "sub clock used");
    chk(n < 300, exp_quick, "wake latency");
    if (exp_sub) begin
      axi_read(wcm_pkg::ADDR_MODE, d, wcm_pkg::AXI_OKAY);
      chk(d[wcm_pkg::MODE_HRDY], 1'b0, "still on sub clock");
      wait_src(wcm_pkg::SRC_HIGH, 8000);
      chk(sysclk_src_o, wcm_pkg::SRC_HIGH, "back on crystal");
    end
    $display("test wake case done");
  endtask

  initial begin
    clk_i = 1'b0;
    reset_i = 1'b1;
    hosc_clk_i = 1'b0;
    losc_clk_i = 1'b0;
    hcnt = 4'h0;
    lcnt = 4'h0;
    wake_i = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    failures = 0;
    checks = 0;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    t_regs();
    t_slow();
    // RC high oscillator: every halt mode, fast wake enable set but without effect
    axi_write(wcm_pkg::ADDR_OCFG, 8'h06, wcm_pkg::AXI_OKAY);
    wake_case(8'h03, 8'h13, wcm_pkg::PM_IDLE_RUN, 1'b0, 1'b1);
    wake_case(8'h02, 8'h13, wcm_pkg::PM_IDLE_STOP, 1'b0, 1'b1);
    wake_case(8'h02, 8'h11, wcm_pkg::PM_SLEEP_LIGHT, 1'b0, 1'b1);
    wake_case(8'h00, 8'h11, wcm_pkg::PM_SLEEP_DEEP, 1'b0, 1'b1);
    // Crystal high oscillator with internal RC low oscillator
    axi_write(wcm_pkg::ADDR_OCFG, 8'h04, wcm_pkg::AXI_OKAY);
    wake_case(8'h02, 8'h11, wcm_pkg::PM_SLEEP_LIGHT, 1'b1, 1'b1);
    wake_case(8'h02, 8'h13, wcm_pkg::PM_IDLE_STOP, 1'b1, 1'b1);
    wake_case(8'h00, 8'h11, wcm_pkg::PM_SLEEP_DEEP, 1'b0, 1'b0);
    wake_case(8'h02, 8'h01, wcm_pkg::PM_SLEEP_LIGHT, 1'b0, 1'b0);
    complete_run();
  end

  // The full run needs about 38k cycles
  initial begin
    repeat (90000) @(posedge clk_i);
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule
`default_nettype wire
